// file: rtl/bsttap_consts.vh
// constants of the boundary-scan test access port
`ifndef BSTTAP_CONSTS_VH
`define BSTTAP_CONSTS_VH

// ---------------------------------------------
// scan register lengths
// ---------------------------------------------
`define BSTTAP_IR_LEN 8
`define BSTTAP_BSC_LEN 52
`define BSTTAP_BCR_LEN 3
`define BSTTAP_ID_LEN 32

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define BSTTAP_IR_PARITY_BIT 7
`define BSTTAP_BSC_OE_HI 51
`define BSTTAP_BSC_OE_LO 48

// ---------------------------------------------
// reset and capture values
// ---------------------------------------------
`define BSTTAP_IR_RESET 8'h81
`define BSTTAP_IR_CAPTURE 8'h81
`define BSTTAP_BSC_OE_RESET 4'h0
`define BSTTAP_BCR_RESET 3'h2
`define BSTTAP_BYP_CAPTURE 1'h0

// ---------------------------------------------
// instruction opcodes, even parity in bit 7
// ---------------------------------------------
`define BSTTAP_OP_EXTEST 8'h00
`define BSTTAP_OP_IDCODE 8'h81
`define BSTTAP_OP_SAMPLE 8'h82
`define BSTTAP_OP_RUNT 8'h09
`define BSTTAP_OP_BCRSCAN 8'h87
`define BSTTAP_OP_BYPASS 8'hff

// ---------------------------------------------
// timing
// ---------------------------------------------
`define BSTTAP_SYNC_STAGES 2

`endif

// file: rtl/bsttap_sync.v
// two-stage synchroniser for the test pins
`default_nettype none

module bsttap_sync #(
    parameter WIDTH = 3
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // ---------------------------------------------
    // stages
    // ---------------------------------------------
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage feeds only the second
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

`default_nettype wire

// file: rtl/bsttap_top.v
// boundary-scan test access port controller and scan registers
`include "bsttap_consts.vh"
`default_nettype none

// Behaviour
// - sample on rising, drive tdo on falling
// - sixteen-state machine, six stable states
// - state advances by tms at rising edge
// - power-up in test-logic-reset, test logic off
// - tms high reaches reset within five clocks
// - reset loads instruction 10000001, identification
// - reset clears chain cells 51 to 48
// - reset loads control chain with 010
// - master passes idle before any test
// - selected test operation runs only in idle
// - select states have no effect, leave next
// - capture-dr loads selected register on exit, except the control chain
// - shift-dr drives tdo lsb at first fall
// - dr shifts each clock after entry cycle
// - dr exits allow resume, tdo off after exit1
// - pause-dr holds the shift contents
// - dr update latches on fall after update-dr
// - capture-ir loads fixed pattern 10000001
// - shift-ir drives tdo lsb at first fall
// - ir shifts each clock after entry cycle
// - only one register in serial path
// - lengths 8, 52, 3, 1, 32 bits
// - new instruction takes effect on fall
// - tdo off after exit1-ir, no recapture
// - bad parity or unknown opcode acts bypass
module bsttap_top #(
    parameter [31:0] ID_CODE = 32'h0a5a5001 // arbitrary value
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire [`BSTTAP_BSC_LEN-1:0] i_bsc_pins,
    output wire o_tdo,
    output wire o_tdo_oe,
    output wire [3:0] o_tap_state,
    output wire o_test_mode,
    output wire o_test_run,
    output wire [`BSTTAP_BCR_LEN-1:0] o_test_op,
    output wire [`BSTTAP_BSC_LEN-1:0] o_bsc_out
);

    // ---------------------------------------------
    // states
    // ---------------------------------------------
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SHIFT_DR = 4'h4;
    localparam [3:0] ST_EXIT1_DR = 4'h5;
    localparam [3:0] ST_PAUSE_DR = 4'h6;
    localparam [3:0] ST_EXIT2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'ha;
    localparam [3:0] ST_SHIFT_IR = 4'hb;
    localparam [3:0] ST_EXIT1_IR = 4'hc;
    localparam [3:0] ST_PAUSE_IR = 4'hd;
    localparam [3:0] ST_EXIT2_IR = 4'he;
    localparam [3:0] ST_UPD_IR = 4'hf;

    // ---------------------------------------------
    // data register selection codes
    // ---------------------------------------------
    localparam [1:0] SEL_BYP = 2'h0;
    localparam [1:0] SEL_ID = 2'h1;
    localparam [1:0] SEL_BSC = 2'h2;
    localparam [1:0] SEL_BCR = 2'h3;

    // ---------------------------------------------
    // pin synchronisation and edge finding
    // ---------------------------------------------
    wire [2:0] pins_sync;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    reg tck_d_r;
    wire tck_rise;
    wire tck_fall;
    wire [`BSTTAP_BSC_LEN-1:0] bsc_pins_s;

    bsttap_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async({i_tck, i_tms, i_tdi}),
        .o_sync(pins_sync)
    );

    // pin values come from another domain, so they take the same two stages
    bsttap_sync #(
        .WIDTH(`BSTTAP_BSC_LEN)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(i_bsc_pins),
        .o_sync(bsc_pins_s)
    );

    assign tck_s = pins_sync[2];
    assign tms_s = pins_sync[1];
    assign tdi_s = pins_sync[0];

    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    // tms and tdi share the tck pipeline depth, so they line up with the edge
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    // ---------------------------------------------
    // state machine
    // ---------------------------------------------
    reg [3:0] state_r;
    reg [3:0] state_nxt;

    // every state with tms high heads toward reset in at most five steps
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: state_nxt = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_RESET;
        endcase
    end

    // power-up lands in reset; the master must then walk through idle
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ST_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // ---------------------------------------------
    // instruction decode
    // ---------------------------------------------
    reg [`BSTTAP_IR_LEN-1:0] ir_sh_r;
    reg [`BSTTAP_IR_LEN-1:0] ir_r;
    wire ir_parity_ok;
    reg [1:0] dr_sel;
    reg ir_test_mode;

    assign ir_parity_ok = ~(^ir_r);

    // unsupported or odd-parity opcodes fall back to bypass
    always @* begin
        dr_sel = SEL_BYP;
        ir_test_mode = 1'b0;
        if (ir_parity_ok) begin
            case (ir_r)
                `BSTTAP_OP_IDCODE: begin
                    dr_sel = SEL_ID;
                end
                `BSTTAP_OP_SAMPLE: begin
                    dr_sel = SEL_BSC;
                end
                `BSTTAP_OP_EXTEST: begin
                    dr_sel = SEL_BSC;
                    ir_test_mode = 1'b1;
                end
                `BSTTAP_OP_RUNT: begin
                    dr_sel = SEL_BYP;
                    ir_test_mode = 1'b1;
                end
                `BSTTAP_OP_BCRSCAN: begin
                    dr_sel = SEL_BCR;
                end
                default: begin
                    dr_sel = SEL_BYP;
                end
            endcase
        end
    end

    // ---------------------------------------------
    // instruction register
    // ---------------------------------------------
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ir_sh_r <= `BSTTAP_IR_RESET;
            ir_r <= `BSTTAP_IR_RESET;
        end else if (state_r == ST_RESET) begin
            ir_sh_r <= `BSTTAP_IR_RESET;
            ir_r <= `BSTTAP_IR_RESET;
        end else if (tck_rise) begin
            if (state_r == ST_CAP_IR) begin
                ir_sh_r <= `BSTTAP_IR_CAPTURE;
            end else if (state_r == ST_SHIFT_IR) begin
                ir_sh_r <= {tdi_s, ir_sh_r[`BSTTAP_IR_LEN-1:1]};
            end
        end else if (tck_fall && state_r == ST_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // ---------------------------------------------
    // data registers
    // ---------------------------------------------
    reg [`BSTTAP_BSC_LEN-1:0] bsc_sh_r;
    reg [`BSTTAP_BSC_LEN-1:0] bsc_upd_r;
    reg [`BSTTAP_BCR_LEN-1:0] bcr_sh_r;
    reg [`BSTTAP_BCR_LEN-1:0] bcr_upd_r;
    reg [`BSTTAP_ID_LEN-1:0] id_sh_r;
    reg byp_r;
    wire dr_cap;
    wire dr_shift;

    // pause and exit states hold every shift register untouched
    assign dr_cap = tck_rise && (state_r == ST_CAP_DR);
    assign dr_shift = tck_rise && (state_r == ST_SHIFT_DR);

    // boundary chain: power-up clears every cell, test-logic-reset only the enable cells
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bsc_sh_r <= {`BSTTAP_BSC_LEN{1'b0}};
            bsc_upd_r <= {`BSTTAP_BSC_LEN{1'b0}};
        end else if (state_r == ST_RESET) begin
            bsc_sh_r[`BSTTAP_BSC_OE_HI:`BSTTAP_BSC_OE_LO] <= `BSTTAP_BSC_OE_RESET;
            bsc_upd_r[`BSTTAP_BSC_OE_HI:`BSTTAP_BSC_OE_LO] <= `BSTTAP_BSC_OE_RESET;
        end else if (dr_sel == SEL_BSC) begin
            if (dr_cap) begin
                bsc_sh_r <= bsc_pins_s;
            end else if (dr_shift) begin
                bsc_sh_r <= {tdi_s, bsc_sh_r[`BSTTAP_BSC_LEN-1:1]};
            end else if (tck_fall && state_r == ST_UPD_DR) begin
                bsc_upd_r <= bsc_sh_r;
            end
        end
    end

    // control chain keeps its contents through capture
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bcr_sh_r <= `BSTTAP_BCR_RESET;
            bcr_upd_r <= `BSTTAP_BCR_RESET;
        end else if (state_r == ST_RESET) begin
            bcr_sh_r <= `BSTTAP_BCR_RESET;
            bcr_upd_r <= `BSTTAP_BCR_RESET;
        end else if (dr_sel == SEL_BCR) begin
            if (dr_shift) begin
                bcr_sh_r <= {tdi_s, bcr_sh_r[`BSTTAP_BCR_LEN-1:1]};
            end else if (tck_fall && state_r == ST_UPD_DR) begin
                bcr_upd_r <= bcr_sh_r;
            end
        end
    end

    // identification and bypass have no update latch
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            id_sh_r <= ID_CODE;
            byp_r <= `BSTTAP_BYP_CAPTURE;
        end else begin
            if (dr_sel == SEL_ID) begin
                if (dr_cap) begin
                    id_sh_r <= ID_CODE;
                end else if (dr_shift) begin
                    id_sh_r <= {tdi_s, id_sh_r[`BSTTAP_ID_LEN-1:1]};
                end
            end
            if (dr_sel == SEL_BYP) begin
                if (dr_cap) begin
                    byp_r <= `BSTTAP_BYP_CAPTURE;
                end else if (dr_shift) begin
                    byp_r <= tdi_s;
                end
            end
        end
    end

    // ---------------------------------------------
    // serial output
    // ---------------------------------------------
    reg tdo_r;
    reg tdo_oe_r;
    reg dr_lsb;

    always @* begin
        case (dr_sel)
            SEL_ID: dr_lsb = id_sh_r[0];
            SEL_BSC: dr_lsb = bsc_sh_r[0];
            SEL_BCR: dr_lsb = bcr_sh_r[0];
            default: dr_lsb = byp_r;
        endcase
    end

    // enabled from a fall in a shift state until the fall in exit1, changed on the falling edge alone
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            if (state_r == ST_SHIFT_DR) begin
                tdo_r <= dr_lsb;
                tdo_oe_r <= 1'b1;
            end else if (state_r == ST_SHIFT_IR) begin
                tdo_r <= ir_sh_r[0];
                tdo_oe_r <= 1'b1;
            end else begin
                tdo_oe_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------
    // test mode and run-test operation
    // ---------------------------------------------
    reg test_mode_r;
    reg test_run_r;

    // a run only counts while the machine sits in idle
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            test_mode_r <= 1'b0;
            test_run_r <= 1'b0;
        end else begin
            test_mode_r <= ir_test_mode && (state_r != ST_RESET);
            test_run_r <= (state_r == ST_IDLE) && ir_parity_ok
                && (ir_r == `BSTTAP_OP_RUNT);
        end
    end

    // ---------------------------------------------
    // outputs
    // ---------------------------------------------
    assign o_tdo = tdo_r;
    assign o_tdo_oe = tdo_oe_r;
    assign o_tap_state = state_r;
    assign o_test_mode = test_mode_r;
    assign o_test_run = test_run_r;
    assign o_test_op = bcr_upd_r;
    assign o_bsc_out = bsc_upd_r;

endmodule

`default_nettype wire

// file: testbench/bsttap_sva.sv
// checker for the test access port outputs
`include "bsttap_consts.vh"
`default_nettype none

module bsttap_sva (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_tck,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [3:0] o_tap_state,
    input wire logic o_test_mode,
    input wire logic o_test_run,
    input wire logic [`BSTTAP_BCR_LEN-1:0] o_test_op,
    input wire logic [`BSTTAP_BSC_LEN-1:0] o_bsc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // ---------------------------------------------
    // tck edges are seen after the synchroniser lag
    // ---------------------------------------------
    a_tdo_on_fall: assert property ($changed(o_tdo) |-> !$past(i_tck))
        else $error("tdo moved outside the low tck phase");
    a_state_on_rise: assert property ($changed(o_tap_state) |-> $past(i_tck))
        else $error("state moved outside the high tck phase");
    a_select_exit: assert property (o_tap_state == 4'h2 |-> ##[1:16]
        (o_tap_state == 4'h3 || o_tap_state == 4'h9))
        else $error("select state not left in one tck");
    a_select_ir_exit: assert property (o_tap_state == 4'h9 |-> ##[1:16]
        (o_tap_state == 4'ha || o_tap_state == 4'h0))
        else $error("instruction select state not left in one tck");
    a_oe_rise: assert property ($rose(o_tdo_oe) |-> !$past(i_tck)
        && (o_tap_state == 4'h4 || o_tap_state == 4'hb))
        else $error("tdo enabled outside shift entry");
    a_oe_drop: assert property ($fell(o_tdo_oe) |-> !$past(i_tck)
        && (o_tap_state == 4'h5 || o_tap_state == 4'hc))
        else $error("tdo released outside exit1");
    a_oe_shift_only: assert property (o_tdo_oe |->
        o_tap_state inside {4'h4, 4'h5, 4'hb, 4'hc})
        else $error("tdo driven in a non shift state");
    a_run_idle: assert property (o_test_run |-> $past(o_tap_state) == 4'h1
        && o_test_mode)
        else $error("test run outside idle");
    // two cycles: the forced values land one sysclk after the state
    a_tlr_values: assert property (o_tap_state == 4'h0 && $past(o_tap_state, 2) == 4'h0
        |-> o_test_op == 3'h2 && o_bsc_out[51:48] == 4'h0 && !o_test_mode)
        else $error("reset state values wrong");
    a_latch_update: assert property ($changed(o_test_op) || $changed(o_bsc_out)
        |-> $past(o_tap_state) inside {4'h8, 4'h0})
        else $error("data latches moved outside update");
    a_mode_update: assert property ($changed(o_test_mode)
        |-> $past(o_tap_state) inside {4'hf, 4'h0})
        else $error("mode moved outside instruction update");
endmodule

bind bsttap_top bsttap_sva bsttap_sva_i (
    .i_sys_clk, .i_nrst, .i_tck, .o_tdo, .o_tdo_oe, .o_tap_state,
    .o_test_mode, .o_test_run, .o_test_op, .o_bsc_out
);
`default_nettype wire

// file: testbench/bsttap_master.sv
// boundary-scan test master model driving the tap pins
`default_nettype none

module bsttap_master (
    input wire logic i_sys_clk,
    input wire logic i_tdo,
    input wire logic i_tdo_oe,
    output var logic o_tck,
    output var logic o_tms,
    output var logic o_tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    // tdi idles high like its pull-up, tck stands still between steps
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // ---------------------------------------------
    // one tck period, four sysclk low then high
    // ---------------------------------------------
    // tms and tdi move with the fall so they are stable around the rise
    task automatic step(input logic m, input logic d, output logic q, output logic e);
        @(posedge i_sys_clk);
        o_tck <= 1'b0;
        o_tms <= m;
        o_tdi <= d;
        repeat (4) @(posedge i_sys_clk);
        o_tck <= 1'b1;
        #1;
        // a released tdo reads inverted, so a missing enable shows up as bad data
        q = i_tdo_oe ? i_tdo : ~i_tdo;
        e = i_tdo_oe;
        repeat (3) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/bsttap_top_bench.sv
// self-checking bench for the test access port
`include "bsttap_consts.vh"
`default_nettype none

module bsttap_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] TB_ID = 32'h0c3c5a97; // arbitrary value
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [51:0] bsc_pins = 52'h0;
    wire tck, tms, tdi, tdo, tdo_oe, test_mode, test_run;
    wire [3:0] tap_state;
    wire [2:0] test_op;
    wire [51:0] bsc_out;
    int err_total = 0;
    int checks_done = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    bsttap_master bsttap_master_i (.i_sys_clk(i_sys_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe),
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
    bsttap_top #(.ID_CODE(TB_ID)) bsttap_top_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_bsc_pins(bsc_pins), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .o_tap_state(tap_state), .o_test_mode(test_mode),
        .o_test_run(test_run), .o_test_op(test_op), .o_bsc_out(bsc_out));
    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // tms bits lsb first, then wait out the synchroniser lag
    task automatic walk(input logic [7:0] bits, input int n);
        logic q, e;
        for (int k = 0; k < n; k++) begin
            bsttap_master_i.step(bits[k], 1'b1, q, e);
        end
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
    // idle to idle scan; pz > 0 parks in pause after bit pz-1
    task automatic scan(input logic ir, input int n, input logic [63:0] din, input int pz,
        output logic [63:0] dout);
        logic q, e;
        dout = 64'h0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int k = 0; k < n; k++) begin
            bsttap_master_i.step(k == n - 1 || k == pz - 1, din[k], dout[k], e);
            chk("oe in shift", 64'h1, 64'(e));
            if (k == pz - 1) begin
                bsttap_master_i.step(1'b0, 1'b1, q, e);
                chk("oe in pause", 64'h0, 64'(e));
                walk(8'h02, 3);
            end
        end
        walk(8'h01, 2);
        chk("oe in idle", 64'h0, 64'(tdo_oe));
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset;
        chk("state", 64'h0, 64'(tap_state));
        chk("test op", 64'h2, 64'(test_op));
        chk("chain oe cells", 64'h0, 64'(bsc_out[51:48]));
        chk("mode", 64'h0, 64'(test_mode));
        $display("test reset done");
    endtask
    task automatic t_idcode;
        logic [63:0] d;
        walk(8'h00, 1);
        scan(1'b0, 32, 64'h0, 16, d);
        chk("ident", 64'(TB_ID), d);
        $display("test ident done");
    endtask
    task automatic t_ir;
        logic [63:0] d;
        logic [7:0] ops [2] = '{8'hff, 8'h01};
        foreach (ops[i]) begin
            scan(1'b1, 8, 64'(ops[i]), 0, d);
            chk("ir capture", 64'h81, d);
            scan(1'b0, 4, 64'h5, 0, d);
            chk("bypass path", 64'ha, d);
        end
        $display("test ir done");
    endtask
    task automatic t_sample;
        logic [63:0] d;
        @(posedge i_sys_clk);
        bsc_pins <= 52'h5a5a5a5a5a5a5;
        scan(1'b1, 8, 64'h82, 0, d);
        scan(1'b0, 52, 64'hc3c3c3c3c3c3c, 0, d);
        chk("chain capture", 64'h5a5a5a5a5a5a5, d);
        chk("chain update", 64'hc3c3c3c3c3c3c, 64'(bsc_out));
        scan(1'b1, 8, 64'h00, 0, d);
        chk("ir capture", 64'h81, d);
        chk("drive mode", 64'h1, 64'(test_mode));
        scan(1'b0, 52, 64'h3c3c3c3c3c3c3, 0, d);
        chk("drive capture", 64'h5a5a5a5a5a5a5, d);
        chk("drive update", 64'h3c3c3c3c3c3c3, 64'(bsc_out));
        // parked in shift, the way home needs all five clocks
        walk(8'h01, 3);
        walk(8'h1f, 5);
        chk("reset state", 64'h0, 64'(tap_state));
        chk("chain oe cells", 64'h0, 64'(bsc_out[51:48]));
        chk("reset mode", 64'h0, 64'(test_mode));
        walk(8'h00, 1);
        $display("test sample done");
    endtask
    task automatic t_run;
        logic [63:0] d;
        scan(1'b1, 8, 64'h87, 0, d);
        scan(1'b0, 3, 64'h5, 0, d);
        chk("control capture", 64'h2, d);
        chk("control update", 64'h5, 64'(test_op));
        scan(1'b1, 8, 64'h09, 0, d);
        chk("mode", 64'h1, 64'(test_mode));
        chk("run in idle", 64'h1, 64'(test_run));
        walk(8'h01, 1);
        chk("run left idle", 64'h0, 64'(test_run));
        walk(8'h1f, 5);
        chk("reset state", 64'h0, 64'(tap_state));
        chk("reset op", 64'h2, 64'(test_op));
        chk("reset mode", 64'h0, 64'(test_mode));
        $display("test run done");
    endtask
    // ---------------------------------------------
    // sequence and watchdog
    // ---------------------------------------------
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        t_reset();
        t_idcode();
        t_ir();
        t_sample();
        t_run();
        tally_and_finish();
    end
    // about 19 us of traffic, so 200 us means a hang
    initial begin
        #200000;
        err_total++;
        $display("[ERR] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
